// *** rpc_defines.svh ***
// How it works
// - A positive zero crossing of the fine start phase opens the counting gate.
// - While the gate is open the count rises once per 2.048 MHz tick.
// - A positive zero crossing of the stop phase closes the gate and holds the count.
// - The held count is the start-to-stop phase difference, i.e. the gimbal angle.
// - Fine phase is 64 times the shaft angle; conversion uses that scale.
// - Fine winding makes 64 electrical turns per rev, so fine counts are ambiguous.
// - Coarse start has its own network; coarse stop is the excitation reference crossing.
// - The coarse channel uses the same gate-and-count procedure as the fine one.
// - The coarse angle is output only when the fine channel has failed; otherwise it picks the fine cycle.
// - Fine and coarse excitation references are separate and watched independently.
// - Excitation runs at 1016 Hz; one measurement per excitation period.
`ifndef RPC_DEFINES_SVH
`define RPC_DEFINES_SVH

// ==========================================================
// Timing
`define RPC_SYS_HZ 100000000
`define RPC_MEAS_HZ 2048000
`define RPC_EXC_HZ 1016
`define RPC_ACC_STEP (17'((`RPC_MEAS_HZ) / 1000))
`define RPC_ACC_MOD (17'((`RPC_SYS_HZ) / 1000))
`define RPC_PERIOD_TICKS (12'((`RPC_MEAS_HZ) / (`RPC_EXC_HZ)))
`define RPC_TIMEOUT_TICKS (12'(2 * ((`RPC_MEAS_HZ) / (`RPC_EXC_HZ))))

// ==========================================================
// Angle scaling
`define RPC_FINE_MULT 64
`define RPC_SECTOR_BITS 6
`define RPC_FRAC_MUL 16'h820C
`define RPC_FRAC_SHIFT 10

// ==========================================================
// Pin indices
`define RPC_PIN_FSTART 0
`define RPC_PIN_FSTOP 1
`define RPC_PIN_CSTART 2
`define RPC_PIN_FREF 3
`define RPC_PIN_CREF 4
`define RPC_NPINS 5

`endif

// *** rpc_pkg.sv ***
package rpc_pkg;
  typedef enum logic [1:0] {
    RPC_IDLE = 2'b01,
    RPC_GATE = 2'b10
  } rpc_state_t;

  typedef struct packed {
    logic [15:0] angle;
    logic [11:0] fine_count;
    logic [11:0] coarse_count;
    logic coarse_used;
    logic fine_fail;
    logic coarse_fail;
  } rpc_result_t;

  typedef struct packed {
    rpc_state_t state;
    logic [11:0] count;
    logic [11:0] held;
    logic valid;
    logic fault;
    logic [11:0] idle_ticks;
  } rpc_chan_st_t;
endpackage : rpc_pkg

// *** rpc_chan.sv ***
`timescale 1ns/100ps
`include "rpc_defines.svh"

module rpc_chan
  import rpc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Events
  input wire logic tick,
  input wire logic start,
  input wire logic stop,
  // Result
  output logic [11:0] held,
  output logic valid,
  output logic fault,
  output logic gate_open
);
  rpc_chan_st_t q, d;

  always_comb begin
    d = q;
    d.valid = 1'b0;
    case (q.state)
      RPC_IDLE: begin
        if (tick && q.idle_ticks < `RPC_TIMEOUT_TICKS) begin
          d.idle_ticks = q.idle_ticks + 12'h001;
        end
        if (q.idle_ticks >= `RPC_TIMEOUT_TICKS) begin
          d.fault = 1'b1;
        end
        if (start) begin
          d.state = RPC_GATE;
          d.count = 12'h000;
          d.idle_ticks = 12'h000;
        end
      end
      RPC_GATE: begin
        if (start) begin
          d.count = 12'h000;
        end else if (stop) begin
          d.held = q.count;
          d.valid = 1'b1;
          d.fault = 1'b0;
          d.state = RPC_IDLE;
        end else if (q.count >= `RPC_TIMEOUT_TICKS) begin
          d.fault = 1'b1;
          d.state = RPC_IDLE;
        end else if (tick) begin
          d.count = q.count + 12'h001;
        end
      end
      default: begin
        d.state = RPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{state: RPC_IDLE, count: 12'h000, held: 12'h000, valid: 1'b0,
             fault: 1'b0, idle_ticks: 12'h000};
    end else begin
      q <= d;
    end
  end

  assign held = q.held;
  assign valid = q.valid;
  assign fault = q.fault;
  assign gate_open = (q.state == RPC_GATE);

  // ==========================================================
  // Checks
  gate_opens_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.state == RPC_IDLE && start) |=> (q.state == RPC_GATE && q.count == 12'h000))
    else $error("gate did not open cleared on start");
  count_inc_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.state == RPC_GATE && tick && !start && !stop && q.count < `RPC_TIMEOUT_TICKS)
    |=> q.count == $past(q.count) + 12'h001)
    else $error("count did not advance on tick");
  count_still_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.state == RPC_GATE && !tick && !start) |=> $stable(q.count))
    else $error("count moved without tick");
  stop_closes_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.state == RPC_GATE && stop && !start)
    |=> (q.state == RPC_IDLE && valid && held == $past(q.count)))
    else $error("stop did not close gate and hold count");
  held_steady_a: assert property (@(posedge clk) disable iff (!rst_n)
    !valid |-> $stable(q.held))
    else $error("held count changed without a result");
  restart_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.state == RPC_GATE && start) |=> q.count == 12'h000)
    else $error("restart did not clear count");

  meas_done_c: cover property (@(posedge clk) disable iff (!rst_n)
    (q.state == RPC_GATE && q.count > 12'h010 && stop));
  timeout_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(q.fault));
endmodule : rpc_chan

// *** rpc_top.sv ***
`timescale 1ns/100ps
`include "rpc_defines.svh"

module rpc_top
  import rpc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Zero-crossing pulses from the bridge comparators
  input wire logic start_phase_zc,
  input wire logic stop_phase_zc,
  input wire logic coarse_start_zc,
  // Excitation references, one per channel
  input wire logic fine_resolver_excitation,
  input wire logic coarse_resolver_excitation,
  // Result
  output rpc_result_t result,
  output logic result_valid
);
  typedef struct packed {
    logic [16:0] acc;
    logic tick;
    logic [`RPC_NPINS-1:0] s1;
    logic [`RPC_NPINS-1:0] s2;
    logic [`RPC_NPINS-1:0] prev;
    logic [11:0] fref_wd;
    logic [11:0] cref_wd;
    logic [15:0] cfrac;
    rpc_result_t res;
    logic res_valid;
  } rpc_top_st_t;

  rpc_top_st_t q, d;
  logic [`RPC_NPINS-1:0] pins, edges;
  logic [11:0] fine_held, coarse_held;
  logic fine_valid, coarse_valid, fine_fault, coarse_fault;
  logic fine_fail, coarse_fail;
  logic [15:0] fine_frac, coarse_frac;
  logic [5:0] sector;

  // Count to 16-bit turn fraction, saturating
  function automatic logic [15:0] rpc_to_frac(input logic [11:0] cnt);
    logic [27:0] prod;
    prod = 28'(cnt) * 28'(`RPC_FRAC_MUL);
    if (prod[27:26] != 2'h0) begin
      rpc_to_frac = 16'hFFFF;
    end else begin
      rpc_to_frac = prod[`RPC_FRAC_SHIFT +: 16];
    end
  endfunction : rpc_to_frac

  assign pins = {coarse_resolver_excitation, fine_resolver_excitation, coarse_start_zc, stop_phase_zc,
                 start_phase_zc};
  assign edges = q.s2 & ~q.prev;

  // ==========================================================
  // Channels
  rpc_chan u_fine (
    .clk(clk),
    .rst_n(rst_n),
    .tick(q.tick),
    .start(edges[`RPC_PIN_FSTART]),
    .stop(edges[`RPC_PIN_FSTOP]),
    .held(fine_held),
    .valid(fine_valid),
    .fault(fine_fault),
    .gate_open()
  );

  rpc_chan u_coarse (
    .clk(clk),
    .rst_n(rst_n),
    .tick(q.tick),
    .start(edges[`RPC_PIN_CSTART]),
    .stop(edges[`RPC_PIN_CREF]),
    .held(coarse_held),
    .valid(coarse_valid),
    .fault(coarse_fault),
    .gate_open()
  );

  // ==========================================================
  // Health and angle
  assign fine_fail = fine_fault || (q.fref_wd >= `RPC_TIMEOUT_TICKS);
  assign coarse_fail = coarse_fault || (q.cref_wd >= `RPC_TIMEOUT_TICKS);
  assign fine_frac = rpc_to_frac(fine_held);
  assign coarse_frac = rpc_to_frac(coarse_held);
  // Coarse picks which of the 64 fine cycles, centred on fine phase
  assign sector = 6'((q.cfrac - {6'h00, fine_frac[15:6]} + 16'h0200) >> 10);

  always_comb begin
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
    d.prev = q.s2;
    d.res_valid = 1'b0;
    d.tick = 1'b0;
    if (q.acc + `RPC_ACC_STEP >= `RPC_ACC_MOD) begin
      d.acc = q.acc + `RPC_ACC_STEP - `RPC_ACC_MOD;
      d.tick = 1'b1;
    end else begin
      d.acc = q.acc + `RPC_ACC_STEP;
    end
    // Reference watchdogs: one period per crossing expected
    if (edges[`RPC_PIN_FREF]) begin
      d.fref_wd = 12'h000;
    end else if (q.tick && q.fref_wd < `RPC_TIMEOUT_TICKS) begin
      d.fref_wd = q.fref_wd + 12'h001;
    end
    if (edges[`RPC_PIN_CREF]) begin
      d.cref_wd = 12'h000;
    end else if (q.tick && q.cref_wd < `RPC_TIMEOUT_TICKS) begin
      d.cref_wd = q.cref_wd + 12'h001;
    end
    d.res.fine_fail = fine_fail;
    d.res.coarse_fail = coarse_fail;
    if (coarse_valid) begin
      d.cfrac = coarse_frac;
      d.res.coarse_count = coarse_held;
      if (fine_fail) begin
        d.res.angle = coarse_frac;
        d.res.coarse_used = 1'b1;
        d.res_valid = 1'b1;
      end
    end
    if (fine_valid && !fine_fail) begin
      d.res.fine_count = fine_held;
      d.res.angle = {sector, fine_frac[15:6]};
      d.res.coarse_used = 1'b0;
      d.res_valid = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign result = q.res;
  assign result_valid = q.res_valid;

  // ==========================================================
  // Checks
  tick_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
    q.tick |=> !q.tick [*8])
    else $error("measurement ticks too close");
  tick_due_a: assert property (@(posedge clk) disable iff (!rst_n)
    !q.tick |-> ##[0:49] q.tick)
    else $error("measurement tick overdue");
  fine_pref_a: assert property (@(posedge clk) disable iff (!rst_n)
    (fine_valid && !fine_fail) |=> (result_valid && !result.coarse_used))
    else $error("fine result not preferred");
  coarse_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    (result_valid && result.coarse_used) |-> $past(fine_fail))
    else $error("coarse used while fine healthy");
  fine_scale_a: assert property (@(posedge clk) disable iff (!rst_n)
    (fine_valid && !fine_fail) |=> result.angle[9:0] == $past(fine_frac[15:6]))
    else $error("fine angle scaling wrong");
  ref_loss_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.fref_wd >= `RPC_TIMEOUT_TICKS) |=> result.fine_fail)
    else $error("lost fine reference not flagged");
  sync_lat_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(start_phase_zc) ##1 start_phase_zc ##1 start_phase_zc |-> edges[`RPC_PIN_FSTART])
    else $error("start edge not seen two cycles later");

  fine_res_c: cover property (@(posedge clk) disable iff (!rst_n) result_valid && !result.coarse_used);
  coarse_res_c: cover property (@(posedge clk) disable iff (!rst_n) result_valid && result.coarse_used);
  ref_lost_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(q.fref_wd >= `RPC_TIMEOUT_TICKS));
endmodule : rpc_top

// *** rpc_bridge_model.sv ***
`timescale 1ns/100ps
module rpc_bridge_model #(
  parameter int EXC_HALF = 49212
) (
  // Clock
  input wire logic clk,
  // Zero-crossing pins
  output logic start_phase_zc,
  output logic stop_phase_zc,
  output logic coarse_start_zc,
  // Excitation references
  output logic fine_resolver_excitation,
  output logic coarse_resolver_excitation
);
  logic [2:0] zc;
  int wid [3];
  int exc_cnt;

  assign start_phase_zc = zc[0];
  assign stop_phase_zc = zc[1];
  assign coarse_start_zc = zc[2];

  initial begin
    zc = 3'h0;
    wid = '{0, 0, 0};
    exc_cnt = 0;
    fine_resolver_excitation = 1'b0;
    coarse_resolver_excitation = 1'b0;
  end

  // ==========
  // Both references from one divider at 1016 Hz
  always @(posedge clk) begin
    exc_cnt <= (exc_cnt == EXC_HALF - 1) ? 0 : exc_cnt + 1;
    if (exc_cnt == EXC_HALF - 1) begin
      fine_resolver_excitation <= ~fine_resolver_excitation;
      coarse_resolver_excitation <= ~coarse_resolver_excitation;
    end
  end

  // ==========
  // Comparator pulses, 4 clk wide, idle low
  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (wid[i] == 1) begin
        zc[i] <= 1'b0;
      end
      if (wid[i] > 0) begin
        wid[i] <= wid[i] - 1;
      end
    end
  end

  task automatic fire(input int pin);
    @(posedge clk);
    zc[pin] <= 1'b1;
    wid[pin] <= 4;
  endtask : fire
endmodule : rpc_bridge_model

// *** testbench.sv ***
`timescale 1ns/100ps
module testbench;
  import rpc_pkg::*;
  logic clk;
  logic rst_n;
  logic start_phase_zc;
  logic stop_phase_zc;
  logic coarse_start_zc;
  logic fine_resolver_excitation;
  logic coarse_resolver_excitation;
  rpc_result_t result;
  logic result_valid;
  logic [11:0] cnt;
  int err_total;
  int checks;

  rpc_top u_dut (.clk(clk), .rst_n(rst_n), .start_phase_zc(start_phase_zc), .stop_phase_zc(stop_phase_zc),
    .coarse_start_zc(coarse_start_zc), .fine_resolver_excitation(fine_resolver_excitation),
    .coarse_resolver_excitation(coarse_resolver_excitation), .result(result), .result_valid(result_valid));
  rpc_bridge_model u_bm (.clk(clk), .start_phase_zc(start_phase_zc), .stop_phase_zc(stop_phase_zc),
    .coarse_start_zc(coarse_start_zc), .fine_resolver_excitation(fine_resolver_excitation),
    .coarse_resolver_excitation(coarse_resolver_excitation));

  always #5 clk = ~clk;

  // ==========
  // Checking helpers
  task automatic tally_and_finish();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_near(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if ($isunknown(got) || !(got >= exp - 12'h001 && got <= exp + 12'h001)) begin
      err_total++;
      $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_near

  // Start, stop gap clk later, wait for the published result
  task automatic measure(input int gap);
    logic seen;
    seen = 1'b0;
    u_bm.fire(0);
    repeat (gap - 1) @(posedge clk);
    u_bm.fire(1);
    for (int i = 0; i < 12 && !seen; i++) begin
      @(posedge clk);
      #1;
      seen = (result_valid === 1'b1);
    end
    if (!seen) begin
      err_total++;
      $display("[ERR] %0t got=%h exp=%h", $time, 1'b0, 1'b1);
      tally_and_finish();
    end
    cnt = result.fine_count;
    @(posedge clk);
    #1;
    chk(48'(result_valid), 48'h0);
  endtask : measure

  // ==========
  // Scenarios
  task automatic sc_fine(input int gap);
    int f;
    int c;
    logic [15:0] s;
    measure(gap);
    chk_near(cnt, 12'(gap * 2048 / 100000));
    chk(48'(result.coarse_used), 48'h0);
    f = (int'(cnt) * 32'h0000820C) >> 10;
    f = (f > 32'h0000FFFF) ? 32'h0000FFFF : f;
    chk(48'(result.angle[9:0]), 48'(f[15:6]));
    // Sector from the last coarse count, centred on the fine phase
    c = (int'(result.coarse_count) * 32'h0000820C) >> 10;
    c = (c > 32'h0000FFFF) ? 32'h0000FFFF : c;
    s = 16'(c - int'(f[15:6]) + 32'h00000200);
    chk(48'(result.angle[15:10]), 48'(s[15:10]));
  endtask : sc_fine

  task automatic sc_restart();
    u_bm.fire(0);
    repeat (3000) @(posedge clk);
    measure(1000);
    chk_near(cnt, 12'h014);
  endtask : sc_restart

  task automatic sc_stray_stop();
    int hits;
    hits = 0;
    u_bm.fire(1);
    repeat (20) begin
      @(posedge clk);
      #1;
      hits += (result_valid !== 1'b0);
    end
    chk(48'(hits), 48'h0);
    chk(48'(result.fine_count), 48'(cnt));
  endtask : sc_stray_stop

  // Coarse start, then the coarse reference edge stops it; unpublished while fine is healthy
  task automatic sc_coarse();
    int hits;
    int gap;
    logic ref_was;
    hits = 0;
    gap = 0;
    ref_was = coarse_resolver_excitation;
    u_bm.fire(2);
    for (int i = 1; i <= 60000; i++) begin
      @(posedge clk);
      #1;
      hits += (result_valid !== 1'b0);
      if (gap == 0 && ref_was === 1'b0 && coarse_resolver_excitation === 1'b1) begin
        gap = i;
      end
      ref_was = coarse_resolver_excitation;
    end
    chk(48'(hits), 48'h0);
    chk_near(result.coarse_count, 12'(gap * 2048 / 100000));
    chk(48'({result.coarse_used, result.fine_fail, result.coarse_fail}), 48'h0);
  endtask : sc_coarse

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    err_total = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    #1;
    chk(48'({result, result_valid}), 48'h0);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    sc_fine(500);
    sc_fine(2000);
    sc_fine(9000);
    sc_restart();
    sc_stray_stop();
    sc_coarse();
    sc_fine(3000);
    tally_and_finish();
  end
endmodule : testbench
